// File: pkg/turn_on_seq_pkg.sv
/*
 Shared constants, types and helpers for the turn-on sequencer and its millisecond divider.
 Assumes a 20 MHz system clock and PMBus commands already framed by the transport layer.
*/
package turn_on_seq_pkg;

   // Clock and time base
   localparam int CLK_PERIOD_NS = 50;
   localparam int MS_IN_NS = 1000000;
   localparam int CYCLES_PER_MS = MS_IN_NS / CLK_PERIOD_NS;

   // Command codes of the four settings
   localparam logic [7:0] CMD_TURN_ON_DELAY = 8'h60;
   localparam logic [7:0] CMD_TURN_ON_RISE = 8'h61;
   localparam logic [7:0] CMD_TURN_ON_LIMIT = 8'h62;
   localparam logic [7:0] CMD_TURN_ON_RESP = 8'h63;

   // Reset values
   localparam logic [15:0] RST_WORD = 16'h0000;
   localparam logic [7:0] RST_RESP = 8'h00;

   // Response byte fields
   localparam int RESP_MODE_HI = 7;
   localparam int RESP_MODE_LO = 6;
   localparam int RESP_RETRY_HI = 5;
   localparam int RESP_RETRY_LO = 3;
   localparam int RESP_DELAY_HI = 2;
   localparam int RESP_DELAY_LO = 0;
   localparam logic [2:0] RETRY_NONE = 3'h0;
   localparam logic [2:0] RETRY_FOREVER = 3'h7;

   // Linear format fields
   localparam int LIN_EXP_HI = 15;
   localparam int LIN_EXP_LO = 11;
   localparam int LIN_MANT_HI = 10;

   // Reference full scale
   localparam logic [15:0] REF_FULL = 16'hffff;

   typedef enum logic [1:0]
   {
      RESP_IGNORE = 2'h0,
      RESP_DEFER = 2'h1,
      RESP_DISABLE_RETRY = 2'h2,
      RESP_RESUME_OK = 2'h3
   } resp_mode_t;

   typedef enum logic [3:0]
   {
      ST_OFF = 4'h0,
      ST_DELAY = 4'h1,
      ST_RISE = 4'h2,
      ST_ON = 4'h3,
      ST_DEFER = 4'h4,
      ST_RETRY_WAIT = 4'h5,
      ST_LATCHED = 4'h6,
      ST_HOLD = 4'h7
   } seq_state_t;

   // Linear word to whole milliseconds, saturating; negative values give zero
   function automatic logic [15:0] linear_to_ms(input logic [15:0] v);
      logic signed [4:0] e;
      logic [31:0] wide;
      e = v[LIN_EXP_HI:LIN_EXP_LO];
      wide = 32'h0000_0000;
      if (!v[LIN_MANT_HI])
      begin
         if (e >= 0)
            wide = {21'h00000, v[LIN_MANT_HI:0]} << e;
         else
            wide = {21'h00000, v[LIN_MANT_HI:0]} >> (-e);
      end
      linear_to_ms = (wide[31:16] != 16'h0000) ? 16'hffff : wide[15:0];
   endfunction

endpackage

// File: logic/ms_tick_gen.sv
/*
 Free-running divider giving a one-cycle enable pulse every millisecond.
 Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ns
module ms_tick_gen
#(
   parameter int CYCLES = turn_on_seq_pkg::CYCLES_PER_MS
)
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic sys_rst_in,
   // Millisecond enable
   output logic tick_out
);

   typedef struct packed
   {
      logic [19:0] count;
      logic tick;
   } tick_state_t;

   tick_state_t s;
   tick_state_t next_s;

   always_comb
   begin
      next_s = s;
      next_s.tick = 1'b0;
      if (s.count >= 20'(CYCLES - 1))
      begin
         next_s.count = 20'h00000;
         next_s.tick = 1'b1;
      end
      else
         next_s.count = s.count + 20'h00001;
   end

   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
         s <= '0;
      else
         s <= next_s;
   end

   assign tick_out = s.tick;

endmodule

// File: logic/turn_on_sequencer.sv
/*
 Output turn-on sequencer: turn-on delay, rise ramp, turn-on timeout detection and the
 programmable fault response with retries. Settings arrive as decoded PMBus commands.
 Assumes the PMBus transport layer delivers one command per strobe on this clock, the
 enable pin is asynchronous, and the output comparator is asynchronous.

 // Function
 // - Wait the programmed turn-on delay in ms after enable before ramping.
 // - After the delay, ramp the output reference to target over the rise time.
 // - Raise turn-on timeout fault if undervoltage limit not reached within limit.
 // - A zero timeout limit disables the timeout; keep trying indefinitely.
 // - Ignore code: keep operating without interruption after the fault.
 // - Delayed code: keep running for the interval, then retry if fault remains.
 // - Disable-and-retry code: disable output at once, then follow retry setting.
 // - Resume code: hold output off while fault persists, restart once gone.
 // - Retry field zero: no restart, output stays off until fault cleared.
 // - Retry codes one to six: that many restarts, then stay off until cleared.
 // - Space restart attempts by the delay field interval times the time unit.
 // - Retry code seven: retry forever until commanded off, bias lost, other fault.
 // - Delay field value n means two to the n time units.
 // - Time unit length comes from the output-voltage fault time-unit setting.
*/
`timescale 1ns/1ns
module turn_on_sequencer
#(
   parameter int CYCLES_PER_MS = turn_on_seq_pkg::CYCLES_PER_MS
)
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic sys_rst_in,
   // PMBus command port
   input wire logic [7:0] cmd_code_in,
   input wire logic [15:0] cmd_wr_data_in,
   input wire logic cmd_wr_in,
   input wire logic cmd_rd_in,
   output logic [15:0] cmd_rd_data_out,
   output logic cmd_rd_valid_out,
   output logic cmd_unsupported_out,
   // On/off and supervision
   input wire logic enable_pin_in,
   input wire logic operation_on_in,
   input wire logic bias_ok_in,
   input wire logic shutdown_fault_in,
   input wire logic fault_clear_in,
   input wire logic vout_above_uv_in,
   input wire logic [7:0] vout_fault_unit_ms_in,
   // Power stage control and status
   output logic output_enable_out,
   output logic [15:0] vout_ref_out,
   output logic power_good_out,
   output logic turn_on_fault_out,
   output logic latched_off_out,
   output logic [2:0] retry_count_out
);

   typedef struct packed
   {
      turn_on_seq_pkg::seq_state_t st;
      logic en_meta;
      logic en_sync;
      logic uv_meta;
      logic uv_sync;
      logic [15:0] turn_on_delay_setting;
      logic [15:0] turn_on_rise_time_setting;
      logic [15:0] turn_on_timeout_limit;
      logic [7:0] turn_on_timeout_response;
      logic [15:0] tmr_ms;
      logic [15:0] att_ms;
      logic att_run;
      logic [15:0] ramp_ms;
      logic [23:0] ramp_acc;
      logic [15:0] vref;
      logic [2:0] retries_done;
      logic fault;
      logic out_en;
      logic pgood;
      logic latched;
      logic [15:0] rd_data;
      logic rd_valid;
      logic unsupported;
   } seq_regs_t;

   seq_regs_t s;
   seq_regs_t next_s;
   logic ms_tick;
   logic [15:0] delay_ms;
   logic [15:0] rise_ms;
   logic [15:0] limit_ms;
   logic [15:0] unit_wait_ms;
   logic [1:0] resp_mode;
   logic [2:0] retry_set;
   logic [2:0] delay_code;
   logic run_ok;
   logic timeout;
   logic known_cmd;

   ms_tick_gen #(.CYCLES(CYCLES_PER_MS)) u_ms_tick
   (
      .clk_in(clk_in),
      .sys_rst_in(sys_rst_in),
      .tick_out(ms_tick)
   );

   always_comb
   begin
      delay_ms = turn_on_seq_pkg::linear_to_ms(s.turn_on_delay_setting);
      rise_ms = turn_on_seq_pkg::linear_to_ms(s.turn_on_rise_time_setting);
      limit_ms = turn_on_seq_pkg::linear_to_ms(s.turn_on_timeout_limit);
      resp_mode = s.turn_on_timeout_response[turn_on_seq_pkg::RESP_MODE_HI:turn_on_seq_pkg::RESP_MODE_LO];
      retry_set = s.turn_on_timeout_response[turn_on_seq_pkg::RESP_RETRY_HI:turn_on_seq_pkg::RESP_RETRY_LO];
      delay_code = s.turn_on_timeout_response[turn_on_seq_pkg::RESP_DELAY_HI:turn_on_seq_pkg::RESP_DELAY_LO];
      // Unit length times two to the code; at most 255 << 7, so it fits 16 bits
      unit_wait_ms = {8'h00, vout_fault_unit_ms_in} << delay_code;
      run_ok = s.en_sync & operation_on_in & bias_ok_in & ~shutdown_fault_in;
      // Zero limit means no timeout at all
      timeout = s.att_run && (limit_ms != 16'h0000) && (s.att_ms >= limit_ms) && !s.uv_sync;
      known_cmd = (cmd_code_in == turn_on_seq_pkg::CMD_TURN_ON_DELAY) ||
                  (cmd_code_in == turn_on_seq_pkg::CMD_TURN_ON_RISE) ||
                  (cmd_code_in == turn_on_seq_pkg::CMD_TURN_ON_LIMIT) ||
                  (cmd_code_in == turn_on_seq_pkg::CMD_TURN_ON_RESP);
   end

   always_comb
   begin
      next_s = s;
      next_s.rd_valid = 1'b0;
      next_s.unsupported = 1'b0;

      // Two-flop synchronisers; only the second stage is used below
      next_s.en_meta = enable_pin_in;
      next_s.en_sync = s.en_meta;
      next_s.uv_meta = vout_above_uv_in;
      next_s.uv_sync = s.uv_meta;

      // Command writes and reads
      if (cmd_wr_in)
      begin
         case (cmd_code_in)
            turn_on_seq_pkg::CMD_TURN_ON_DELAY: next_s.turn_on_delay_setting = cmd_wr_data_in;
            turn_on_seq_pkg::CMD_TURN_ON_RISE: next_s.turn_on_rise_time_setting = cmd_wr_data_in;
            turn_on_seq_pkg::CMD_TURN_ON_LIMIT: next_s.turn_on_timeout_limit = cmd_wr_data_in;
            turn_on_seq_pkg::CMD_TURN_ON_RESP: next_s.turn_on_timeout_response = cmd_wr_data_in[7:0];
            default: next_s.unsupported = 1'b1;
         endcase
      end
      if (cmd_rd_in)
      begin
         next_s.rd_valid = known_cmd;
         next_s.unsupported = ~known_cmd;
         case (cmd_code_in)
            turn_on_seq_pkg::CMD_TURN_ON_DELAY: next_s.rd_data = s.turn_on_delay_setting;
            turn_on_seq_pkg::CMD_TURN_ON_RISE: next_s.rd_data = s.turn_on_rise_time_setting;
            turn_on_seq_pkg::CMD_TURN_ON_LIMIT: next_s.rd_data = s.turn_on_timeout_limit;
            turn_on_seq_pkg::CMD_TURN_ON_RESP: next_s.rd_data = {8'h00, s.turn_on_timeout_response};
            default: next_s.rd_data = 16'h0000;
         endcase
      end

      // Fault clear; a new timeout in the same cycle sets the flag again below
      if (fault_clear_in)
      begin
         next_s.fault = 1'b0;
         next_s.retries_done = 3'h0;
      end

      // Millisecond timers
      if (ms_tick && (s.tmr_ms != 16'hffff))
         next_s.tmr_ms = s.tmr_ms + 16'h0001;
      if (s.att_run && ms_tick && (s.att_ms != 16'hffff))
         next_s.att_ms = s.att_ms + 16'h0001;

      // Loss of any run condition overrides every state, latched off included
      if (!run_ok)
      begin
         // Commanded off, bias lost or another shutdown fault ends everything
         next_s.st = turn_on_seq_pkg::ST_OFF;
         next_s.out_en = 1'b0;
         next_s.vref = 16'h0000;
         next_s.att_run = 1'b0;
         next_s.retries_done = 3'h0;
      end
      else
      begin
         case (s.st)
            turn_on_seq_pkg::ST_OFF:
            begin
               // Every turn-on, first or restart, passes through the delay phase
               next_s.st = turn_on_seq_pkg::ST_DELAY;
               next_s.tmr_ms = 16'h0000;
            end
            turn_on_seq_pkg::ST_DELAY:
            begin
               if (s.tmr_ms >= delay_ms)
               begin
                  next_s.st = turn_on_seq_pkg::ST_RISE;
                  next_s.out_en = 1'b1;
                  next_s.vref = 16'h0000;
                  next_s.ramp_ms = 16'h0000;
                  next_s.ramp_acc = 24'h000000;
                  next_s.att_ms = 16'h0000;
                  next_s.att_run = 1'b1;
               end
            end
            turn_on_seq_pkg::ST_RISE, turn_on_seq_pkg::ST_ON, turn_on_seq_pkg::ST_DEFER:
            begin
               // Ramp: spread full scale over the rise time; capped at one step per clock
               if (s.st == turn_on_seq_pkg::ST_RISE || (s.st == turn_on_seq_pkg::ST_DEFER && s.vref != turn_on_seq_pkg::REF_FULL))
               begin
                  if (ms_tick)
                  begin
                     next_s.ramp_ms = s.ramp_ms + 16'h0001;
                     next_s.ramp_acc = s.ramp_acc + {8'h00, turn_on_seq_pkg::REF_FULL};
                  end
                  if (s.ramp_acc >= {8'h00, rise_ms} && s.vref != turn_on_seq_pkg::REF_FULL)
                  begin
                     next_s.ramp_acc = next_s.ramp_acc - {8'h00, rise_ms};
                     next_s.vref = s.vref + 16'h0001;
                  end
                  if (s.ramp_ms >= rise_ms)
                  begin
                     next_s.vref = turn_on_seq_pkg::REF_FULL;
                     if (s.st == turn_on_seq_pkg::ST_RISE)
                        next_s.st = turn_on_seq_pkg::ST_ON;
                  end
               end

               // Reaching regulation ends the attempt and restores the full retry budget
               if (s.uv_sync)
               begin
                  next_s.att_run = 1'b0;
                  next_s.retries_done = 3'h0;
               end

               if (timeout)
               begin
                  next_s.att_run = 1'b0;
                  next_s.fault = 1'b1;
                  case (resp_mode)
                     turn_on_seq_pkg::RESP_IGNORE:
                        next_s.fault = 1'b1;
                     turn_on_seq_pkg::RESP_DEFER:
                     begin
                        next_s.st = turn_on_seq_pkg::ST_DEFER;
                        next_s.tmr_ms = 16'h0000;
                     end
                     turn_on_seq_pkg::RESP_DISABLE_RETRY:
                        next_s = retry_step(next_s);
                     default:
                     begin
                        next_s.st = turn_on_seq_pkg::ST_HOLD;
                        next_s.out_en = 1'b0;
                        next_s.vref = 16'h0000;
                     end
                  endcase
               end
               else if (s.st == turn_on_seq_pkg::ST_DEFER && s.tmr_ms >= unit_wait_ms)
               begin
                  // Still below the limit after the grace interval: fall into retries
                  if (!s.uv_sync)
                     next_s = retry_step(next_s);
                  else
                     next_s.st = turn_on_seq_pkg::ST_RISE;
               end
            end
            turn_on_seq_pkg::ST_RETRY_WAIT:
            begin
               // Delay phase of the restart is added on top of this spacing
               if (s.tmr_ms >= unit_wait_ms)
               begin
                  next_s.st = turn_on_seq_pkg::ST_DELAY;
                  next_s.tmr_ms = 16'h0000;
               end
            end
            turn_on_seq_pkg::ST_LATCHED, turn_on_seq_pkg::ST_HOLD:
            begin
               // Stays off until the fault is cleared, then a fresh turn-on
               // Resume mode takes the clear pulse as the end of the fault condition
               if (fault_clear_in)
                  next_s.st = turn_on_seq_pkg::ST_OFF;
            end
            default:
               next_s.st = turn_on_seq_pkg::ST_OFF;
         endcase
      end

      // Status flags follow the next state so they line up with the output enable
      next_s.latched = (next_s.st == turn_on_seq_pkg::ST_LATCHED);
      next_s.pgood = next_s.out_en && s.uv_sync &&
                     (next_s.st == turn_on_seq_pkg::ST_ON || next_s.st == turn_on_seq_pkg::ST_RISE);
   end

   // Disable the output and either schedule a restart or latch off
   function automatic seq_regs_t retry_step(input seq_regs_t cur);
      seq_regs_t r;
      r = cur;
      r.out_en = 1'b0;
      r.vref = 16'h0000;
      r.att_run = 1'b0;
      r.tmr_ms = 16'h0000;
      // The budget counts restarts, so code n allows n turn-ons after the first one
      // Endless retrying never advances the counter, so it cannot wrap into a latch
      if (retry_set == turn_on_seq_pkg::RETRY_NONE)
         r.st = turn_on_seq_pkg::ST_LATCHED;
      else if (retry_set != turn_on_seq_pkg::RETRY_FOREVER && cur.retries_done >= retry_set)
         r.st = turn_on_seq_pkg::ST_LATCHED;
      else
      begin
         r.st = turn_on_seq_pkg::ST_RETRY_WAIT;
         if (retry_set != turn_on_seq_pkg::RETRY_FOREVER)
            r.retries_done = cur.retries_done + 3'h1;
      end
      retry_step = r;
   endfunction

   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
      begin
         s <= '0;
         s.st <= turn_on_seq_pkg::ST_OFF;
         s.turn_on_delay_setting <= turn_on_seq_pkg::RST_WORD;
         s.turn_on_rise_time_setting <= turn_on_seq_pkg::RST_WORD;
         s.turn_on_timeout_limit <= turn_on_seq_pkg::RST_WORD;
         s.turn_on_timeout_response <= turn_on_seq_pkg::RST_RESP;
      end
      else
         s <= next_s;
   end

   assign cmd_rd_data_out = s.rd_data;
   assign cmd_rd_valid_out = s.rd_valid;
   assign cmd_unsupported_out = s.unsupported;
   assign output_enable_out = s.out_en;
   assign vout_ref_out = s.vref;
   assign power_good_out = s.pgood;
   assign turn_on_fault_out = s.fault;
   assign latched_off_out = s.latched;
   assign retry_count_out = s.retries_done;

endmodule

// File: tb/turn_on_seq_checker.sv
/*
 Port-level assertions for the turn-on sequencer.
 Assumes one clock and a synchronous active-high reset, attached by the bind below.
*/
`timescale 1ns/1ns
module turn_on_seq_checker
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic sys_rst_in,
   // Command port
   input wire logic [7:0] cmd_code_in,
   input wire logic cmd_wr_in,
   input wire logic cmd_rd_in,
   input wire logic [15:0] cmd_rd_data_out,
   input wire logic cmd_rd_valid_out,
   input wire logic cmd_unsupported_out,
   // Supervision and status
   input wire logic bias_ok_in,
   input wire logic fault_clear_in,
   input wire logic output_enable_out,
   input wire logic power_good_out,
   input wire logic turn_on_fault_out,
   input wire logic latched_off_out
);
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (sys_rst_in);
   logic known;
   assign known = (cmd_code_in[7:2] == 6'h18);

   property p_rd_answer;
      cmd_rd_in && known |=> cmd_rd_valid_out && !cmd_unsupported_out;
   endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("read of a setting not answered");
   property p_unsup;
      (cmd_rd_in || cmd_wr_in) && !known |=> cmd_unsupported_out && !cmd_rd_valid_out;
   endproperty
   a_unsup: assert property (p_unsup) else $error("unknown command not refused");
   property p_no_answer;
      !cmd_rd_in |=> !cmd_rd_valid_out;
   endproperty
   a_no_answer: assert property (p_no_answer) else $error("read answer without a read");
   property p_rd_hold;
      !cmd_rd_in |=> $stable(cmd_rd_data_out);
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data changed without a read");
   property p_bias_off;
      !bias_ok_in [*4] |-> !output_enable_out;
   endproperty
   a_bias_off: assert property (p_bias_off) else $error("output on without bias");
   property p_latched;
      latched_off_out |-> !output_enable_out;
   endproperty
   a_latched: assert property (p_latched) else $error("output on while latched off");
   property p_sticky;
      turn_on_fault_out && !fault_clear_in |=> turn_on_fault_out;
   endproperty
   a_sticky: assert property (p_sticky) else $error("fault flag dropped without clear");
   property p_pg;
      power_good_out |-> output_enable_out;
   endproperty
   a_pg: assert property (p_pg) else $error("power good with output disabled");
endmodule

bind turn_on_sequencer turn_on_seq_checker i_chk (.clk_in, .sys_rst_in, .cmd_code_in, .cmd_wr_in,
   .cmd_rd_in, .cmd_rd_data_out, .cmd_rd_valid_out, .cmd_unsupported_out, .bias_ok_in,
   .fault_clear_in, .output_enable_out, .power_good_out, .turn_on_fault_out, .latched_off_out);

// File: tb/pmbus_host_model.sv
/*
 Behavioural management host issuing one command per strobe.
 Assumes the device answers a read one cycle after the strobe.
*/
`timescale 1ns/1ns
module pmbus_host_model
(
   // Clock
   input wire logic clk_in,
   // Command port toward the device
   output logic [7:0] code_out,
   output logic [15:0] data_out,
   output logic wr_out,
   output logic rd_out,
   // Answers from the device
   input wire logic [15:0] rd_data_in,
   input wire logic rd_valid_in,
   input wire logic unsup_in
);
   initial
   begin
      code_out = 8'h00;
      data_out = 16'h0000;
      wr_out = 1'b0;
      rd_out = 1'b0;
   end
   task automatic wr(input logic [7:0] c, input logic [15:0] d);
      @(posedge clk_in);
      code_out <= c;
      data_out <= d;
      wr_out <= 1'b1;
      @(posedge clk_in);
      wr_out <= 1'b0;
      // Released lines show garbage, not the last word
      code_out <= ~c;
      data_out <= ~d;
   endtask
   task automatic rd(input logic [7:0] c, output logic [15:0] d, output logic v, output logic u);
      @(posedge clk_in);
      code_out <= c;
      rd_out <= 1'b1;
      @(posedge clk_in);
      rd_out <= 1'b0;
      code_out <= ~c;
      @(negedge clk_in);
      d = rd_data_in;
      v = rd_valid_in;
      u = unsup_in;
   endtask
endmodule

// File: tb/tb.sv
/*
 Self-checking bench for the turn-on sequencer.
 Assumes a millisecond of ten clocks and a host model on the command port.
*/
`timescale 1ns/1ns
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin fails++; \
   $display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end
module tb;
   localparam int CPM = 10;
   logic clk_in, sys_rst_in, cmd_wr_in, cmd_rd_in, enable_pin_in, operation_on_in, bias_ok_in;
   logic shutdown_fault_in, fault_clear_in, vout_above_uv_in, cmd_rd_valid_out, cmd_unsupported_out;
   logic output_enable_out, power_good_out, turn_on_fault_out, latched_off_out;
   logic [7:0] cmd_code_in, vout_fault_unit_ms_in;
   logic [15:0] cmd_wr_data_in, cmd_rd_data_out, vout_ref_out;
   logic [2:0] retry_count_out;
   int fails, cmp_count;
   turn_on_sequencer #(.CYCLES_PER_MS(CPM)) i_turn_on_sequencer (.clk_in, .sys_rst_in, .cmd_code_in,
      .cmd_wr_data_in, .cmd_wr_in, .cmd_rd_in, .cmd_rd_data_out, .cmd_rd_valid_out, .cmd_unsupported_out,
      .enable_pin_in, .operation_on_in, .bias_ok_in, .shutdown_fault_in, .fault_clear_in,
      .vout_above_uv_in, .vout_fault_unit_ms_in, .output_enable_out, .vout_ref_out, .power_good_out,
      .turn_on_fault_out, .latched_off_out, .retry_count_out);
   pmbus_host_model host (.clk_in, .code_out(cmd_code_in), .data_out(cmd_wr_data_in), .wr_out(cmd_wr_in),
      .rd_out(cmd_rd_in), .rd_data_in(cmd_rd_data_out), .rd_valid_in(cmd_rd_valid_out),
      .unsup_in(cmd_unsupported_out));
   initial
   begin
      clk_in = 1'b0;
      forever #25 clk_in = ~clk_in;
   end
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_in);
   endtask
   task automatic wait_en(input logic v, input int lim, output int n);
      n = 0;
      while (output_enable_out !== v && n < lim)
      begin
         @(negedge clk_in);
         n++;
      end
   endtask
   task automatic wait_flt(input int lim);
      int n;
      n = 0;
      while (turn_on_fault_out !== 1'b1 && n < lim)
      begin
         @(negedge clk_in);
         n++;
      end
   endtask
   task automatic cfg(input logic [15:0] dly, input logic [15:0] lim, input logic [7:0] resp);
      host.wr(8'h60, dly);
      host.wr(8'h61, 16'h0000);
      host.wr(8'h62, lim);
      host.wr(8'h63, {8'h00, resp});
   endtask
   task automatic set_en(input logic v);
      @(posedge clk_in);
      enable_pin_in <= v;
   endtask
   task automatic pulse_clear;
      @(posedge clk_in);
      fault_clear_in <= 1'b1;
      @(posedge clk_in);
      fault_clear_in <= 1'b0;
   endtask
   task automatic shut_off;
      int n;
      set_en(1'b0);
      wait_en(1'b0, 20, n);
      pulse_clear();
   endtask
   task automatic t_regs;
      logic [15:0] d;
      logic v, u;
      for (int i = 0; i < 4; i++)
      begin
         host.rd(8'h60 + i[7:0], d, v, u);
         `CHK("reset_value", 16'h0000, d)
         host.wr(8'h60 + i[7:0], 16'ha5c3);
         host.rd(8'h60 + i[7:0], d, v, u);
         `CHK("readback", (i == 3) ? 16'h00c3 : 16'ha5c3, d)
         `CHK("read_valid", 2'b01, {u, v})
      end
      host.rd(8'h64, d, v, u);
      `CHK("refused", 18'h20000, {u, v, d})
   endtask
   task automatic t_delay;
      int n;
      host.wr(8'h61, 16'h0002);
      set_en(1'b1);
      wait_en(1'b1, 100, n);
      `CHK("turn_on_delay", 1'b1, n >= 2 * CPM && n <= 4 * CPM + 6)
      n = 0;
      while (vout_ref_out !== 16'hffff && n < 100)
      begin
         @(negedge clk_in);
         n++;
      end
      `CHK("rise_time", 1'b1, n >= CPM && n <= 3 * CPM + 2)
      cyc(8 * CPM);
      `CHK("no_limit", 2'b01, {turn_on_fault_out, output_enable_out})
      shut_off();
   endtask
   task automatic t_retry;
      int n;
      cfg(16'h0000, 16'h0002, 8'h89);
      vout_fault_unit_ms_in <= 8'h02;
      set_en(1'b1);
      wait_en(1'b1, 20, n);
      wait_en(1'b0, 5 * CPM, n);
      `CHK("timeout", 1'b1, n >= CPM && n <= 3 * CPM + 4)
      `CHK("first_fault", 5'b10001, {turn_on_fault_out, latched_off_out, retry_count_out})
      wait_en(1'b1, 10 * CPM, n);
      `CHK("retry_gap", 1'b1, n >= 3 * CPM && n <= 5 * CPM + 6)
      wait_en(1'b0, 5 * CPM, n);
      cyc(2);
      `CHK("exhausted", 2'b10, {latched_off_out, output_enable_out})
      cyc(6 * CPM);
      `CHK("stays_off", 1'b0, output_enable_out)
      @(posedge clk_in);
      vout_above_uv_in <= 1'b1;
      pulse_clear();
      wait_en(1'b1, 3 * CPM, n);
      cyc(5);
      `CHK("fresh_start", 7'b1100000, {output_enable_out, power_good_out, turn_on_fault_out,
         latched_off_out, retry_count_out})
      @(posedge clk_in);
      vout_above_uv_in <= 1'b0;
      vout_fault_unit_ms_in <= 8'h01;
      shut_off();
   endtask
   task automatic t_modes;
      int n;
      logic [7:0] resp [3] = '{8'h00, 8'h80, 8'hc0};
      for (int i = 0; i < 3; i++)
      begin
         cfg(16'h0000, 16'h0002, resp[i]);
         set_en(1'b1);
         wait_en(1'b1, 20, n);
         wait_flt(5 * CPM);
         cyc(3 * CPM);
         `CHK("mode_output", i == 0, output_enable_out)
         `CHK("mode_latch", i == 1, latched_off_out)
         if (i != 0)
         begin
            pulse_clear();
            wait_en(1'b1, 3 * CPM, n);
            `CHK("back_on", 1'b1, output_enable_out)
         end
         shut_off();
      end
   endtask
   task automatic t_defer;
      int n;
      cfg(16'h0000, 16'h0002, 8'h78);
      set_en(1'b1);
      wait_en(1'b1, 20, n);
      wait_flt(5 * CPM);
      `CHK("defer_runs", 1'b1, output_enable_out)
      wait_en(1'b0, 4 * CPM, n);
      `CHK("defer_len", 1'b1, n >= 1 && n <= 2 * CPM + 4)
      repeat (8)
      begin
         wait_en(1'b1, 8 * CPM, n);
         wait_en(1'b0, 8 * CPM, n);
      end
      `CHK("retry_forever", 2'b01, {latched_off_out, n < 8 * CPM})
      // Bias loss, operation off and another fault must each end the endless retries
      for (int i = 0; i < 3; i++)
      begin
         @(posedge clk_in);
         {bias_ok_in, operation_on_in, shutdown_fault_in} <= (i == 0) ? 3'h2 : ((i == 1) ? 3'h4 : 3'h7);
         cyc(12 * CPM);
         `CHK("bias_stops", 1'b0, output_enable_out)
         @(posedge clk_in);
         {bias_ok_in, operation_on_in, shutdown_fault_in} <= 3'h6;
         wait_en(1'b1, 8 * CPM, n);
         `CHK("retry_resumes", 1'b1, output_enable_out)
      end
      shut_off();
   endtask
   task automatic stop_test;
      $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial
   begin
      {sys_rst_in, operation_on_in, bias_ok_in} = 3'b111;
      {enable_pin_in, shutdown_fault_in, fault_clear_in, vout_above_uv_in} = 4'h0;
      vout_fault_unit_ms_in = 8'h01;
      repeat (6) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      t_regs();
      cfg(16'h0003, 16'h0000, 8'h00);
      t_delay();
      t_retry();
      t_modes();
      t_defer();
      stop_test();
   end
   initial
   begin
      repeat (20000) @(posedge clk_in);
      fails++;
      stop_test();
   end
endmodule
